// file: rtl/dtsl_core.sv
// debug trigger configuration, run control and status over apb
// assumes cpu access, opcode execute and change-of-flow inputs on clk_i
//
// Notes on behaviour
// [RULE1] trigger config always readable, written only while not armed
// [RULE2] trigger config bits 4 and 5 always read zero
// [RULE3] tag type waits for the matched opcode to execute; force fires
// [RULE4] begin bit 0 fills circularly until trigger; 1 trigger starts fill
// [RULE5] event-only modes ignore begin bit and always run begin traces
// [RULE6] modes 0 to 6 select A, A or B, A then B, event and data modes
// [RULE7] mode 7 triggers inside A..B inclusive, mode 8 outside it
// [RULE8] mode codes 9 to 15 never trigger
// [RULE9] run status register is read only
// [RULE10] match A flag clears at run start, sets on an A match
// [RULE11] match B flag clears at run start, sets on a B match
// [RULE12] armed status mirrors arm bit while enabled; arm write sets it
// [RULE13] begin trace ends on fifo full, end trace on trigger
// [RULE14] writing arm 0 or enable 0 ends the run
// [RULE15] valid count clears at start, holds fifo words at run end
// [RULE16] valid count does not drop as the fifo is read
// [RULE17] host keeps its own tally of words left while reading
// [RULE18] enable cannot become 1 while the device is secure
// [RULE19] low byte read advances the fifo, high byte read does not; the code advances it only while not armed
// [RULE20] flags and count hold after run end until the next arm
`timescale 1ns/1ps
module dtsl_core (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // cpu side
  input  wire dtsl_pkg::dtsl_access_t access_i,
  input  wire logic                  exec_valid_i,
  input  wire logic [15:0]           exec_addr_i,
  input  wire logic                  cof_valid_i,
  input  wire logic [15:0]           cof_addr_i,
  input  wire logic [15:0]           last_opcode_addr_i,
  input  wire logic                  secure_i,
  // comparator values
  input  wire logic [15:0]           cmp_a_value_i,
  input  wire logic [15:0]           cmp_b_value_i,
  // run outputs
  output logic                       trigger_o,
  output logic                       armed_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dtsl_pkg::dtsl_state_t state_reg, state_next;
  logic [7:0]  cfg_reg;
  logic [7:0]  ctl_reg;
  logic        af_reg, bf_reg, a_seen_reg, tag_pend_reg;
  logic [15:0] tag_addr_reg;
  logic [3:0]  cnt_reg;
  logic        pready_reg;
  logic        done, wr_done, rd_done, armed, start, stop, run_end;
  logic        hit_cfg, hit_st, hit_ctl, hit_fh, hit_fl, hit_any;
  logic        a_eq, a_lt, a_gt, b_eq, b_lt, b_gt, bd_eq;
  logic        raw_trig, trig_event, ev_mode, ev_store, push, pop;
  logic        tag_sel, new_en;
  logic [3:0]  mode;
  logic [15:0] push_data, head;
  logic [3:0]  fifo_cnt;
  logic        fifo_full;

  assign done    = psel_i && penable_i && pready_reg;
  assign wr_done = done && pwrite_i;
  assign rd_done = done && !pwrite_i;
  assign hit_cfg = (paddr_i == dtsl_pkg::OFF_TRIG_CFG);
  assign hit_st  = (paddr_i == dtsl_pkg::OFF_RUN_STATUS);
  assign hit_ctl = (paddr_i == dtsl_pkg::OFF_DEBUG_CTRL);
  assign hit_fh  = (paddr_i == dtsl_pkg::OFF_FIFO_HIGH);
  assign hit_fl  = (paddr_i == dtsl_pkg::OFF_FIFO_LOW);
  assign hit_any = hit_cfg || hit_st || hit_ctl || hit_fh || hit_fl;
  assign armed   = (state_reg != dtsl_pkg::ST_IDLE);
  assign mode    = cfg_reg[3:0];
  assign tag_sel = cfg_reg[dtsl_pkg::CFG_TAG_BIT];
  assign new_en  = pwdata_i[dtsl_pkg::CTL_EN_BIT] && !secure_i;

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  dtsl_cmp u_cmp_a (
    .valid_i  (access_i.valid),
    .rd_i     (access_i.rd),
    .addr_i   (access_i.addr),
    .value_i  (cmp_a_value_i),
    .rw_en_i  (ctl_reg[dtsl_pkg::CTL_RWAEN_BIT]),
    .rw_val_i (ctl_reg[dtsl_pkg::CTL_RWA_BIT]),
    .eq_o     (a_eq),
    .below_o  (a_lt),
    .above_o  (a_gt)
  );
  dtsl_cmp u_cmp_b (
    .valid_i  (access_i.valid),
    .rd_i     (access_i.rd),
    .addr_i   (access_i.addr),
    .value_i  (cmp_b_value_i),
    .rw_en_i  (ctl_reg[dtsl_pkg::CTL_RWBEN_BIT]),
    .rw_val_i (ctl_reg[dtsl_pkg::CTL_RWB_BIT]),
    .eq_o     (b_eq),
    .below_o  (b_lt),
    .above_o  (b_gt)
  );
  // full modes: B holds a data byte, qualified by B read/write
  assign bd_eq = (b_eq || b_lt || b_gt) &&
                 (access_i.data == cmp_b_value_i[7:0]);

  // ----------------------------------------------------------------
  // trigger decode
  // ----------------------------------------------------------------
  always_comb begin
    raw_trig = 1'b0;
    ev_mode  = 1'b0;
    case (mode)
      dtsl_pkg::MODE_A_ONLY:     raw_trig = a_eq; // [RULE6]
      dtsl_pkg::MODE_A_OR_B:     raw_trig = a_eq || b_eq; // [RULE6]
      dtsl_pkg::MODE_A_THEN_B:   raw_trig = a_seen_reg && b_eq; // [RULE6]
      dtsl_pkg::MODE_EV_B: begin
        raw_trig = b_eq; // [RULE6]
        ev_mode  = 1'b1;
      end
      dtsl_pkg::MODE_A_THEN_EVB: begin
        raw_trig = a_eq; // [RULE6]
        ev_mode  = 1'b1;
      end
      dtsl_pkg::MODE_A_AND_BD:   raw_trig = a_eq && bd_eq; // [RULE6]
      dtsl_pkg::MODE_A_NOT_BD:   raw_trig = a_eq && !bd_eq; // [RULE6]
      dtsl_pkg::MODE_INSIDE:
        raw_trig = access_i.valid && !a_lt && !b_gt && (a_eq || a_gt); // [RULE7]
      dtsl_pkg::MODE_OUTSIDE:    raw_trig = a_lt || b_gt; // [RULE7]
      default:                   raw_trig = 1'b0; // [RULE8]
    endcase
  end

  // tag waits for execution of the matched opcode
  assign trig_event = armed && (tag_sel ?
                      (tag_pend_reg && exec_valid_i &&
                       exec_addr_i == tag_addr_reg) : raw_trig); // [RULE3]

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  assign start = wr_done && hit_ctl && !armed && new_en &&
                 pwdata_i[dtsl_pkg::CTL_ARM_BIT]; // [RULE12]
  assign stop  = wr_done && hit_ctl && armed &&
                 (!pwdata_i[dtsl_pkg::CTL_ARM_BIT] || !new_en); // [RULE14]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dtsl_pkg::ST_IDLE: begin
        if (start) begin
          if (ev_mode || cfg_reg[dtsl_pkg::CFG_BEGIN_BIT]) begin
            state_next = dtsl_pkg::ST_BEGIN_WAIT; // [RULE4] [RULE5]
          end else begin
            state_next = dtsl_pkg::ST_END_TRACE; // [RULE4]
          end
        end
      end
      dtsl_pkg::ST_END_TRACE: begin
        if (trig_event) begin
          state_next = dtsl_pkg::ST_IDLE; // [RULE13]
        end
      end
      dtsl_pkg::ST_BEGIN_WAIT: begin
        if (trig_event) begin
          state_next = dtsl_pkg::ST_BEGIN_FILL; // [RULE4]
        end
      end
      dtsl_pkg::ST_BEGIN_FILL: begin
        if (fifo_full) begin
          state_next = dtsl_pkg::ST_IDLE; // [RULE13]
        end
      end
      default: state_next = dtsl_pkg::ST_IDLE;
    endcase
    if (stop) begin
      state_next = dtsl_pkg::ST_IDLE; // [RULE14]
    end
  end

  assign run_end = armed && (state_next == dtsl_pkg::ST_IDLE);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= dtsl_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // fifo feed
  // ----------------------------------------------------------------
  assign ev_store = ev_mode && b_eq &&
                    (state_reg == dtsl_pkg::ST_BEGIN_FILL ||
                     (state_reg == dtsl_pkg::ST_BEGIN_WAIT &&
                      mode == dtsl_pkg::MODE_EV_B && trig_event));
  assign push = !fifo_full || state_reg == dtsl_pkg::ST_END_TRACE ?
                (ev_store || (!ev_mode && cof_valid_i &&
                 (state_reg == dtsl_pkg::ST_END_TRACE ||
                  state_reg == dtsl_pkg::ST_BEGIN_FILL))) : 1'b0;
  // event data has an empty high byte, so a high read shows zero
  assign push_data = ev_mode ? {8'h00, access_i.data} : cof_addr_i;
  // reads while armed never advance: sequencing would break
  assign pop = rd_done && hit_fl && !armed; // [RULE19]

  dtsl_fifo u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .clear_i     (start),
    .realign_i   (run_end),
    .push_i      (push),
    .push_data_i (push_data),
    .pop_i       (pop),
    .pop_fill_i  (last_opcode_addr_i),
    .head_o      (head),
    .count_o     (fifo_cnt),
    .full_o      (fifo_full)
  );

  // ----------------------------------------------------------------
  // configuration and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg <= dtsl_pkg::CFG_RESET;
    end else if (wr_done && hit_cfg && !armed) begin // [RULE1]
      cfg_reg <= pwdata_i[7:0] & dtsl_pkg::CFG_WRITE_MASK; // [RULE2]
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_reg <= dtsl_pkg::CTL_RESET;
    end else if (wr_done && hit_ctl) begin
      ctl_reg <= {new_en, 1'b0, pwdata_i[5:0]}; // [RULE18]
    end
  end

  // ----------------------------------------------------------------
  // match tracking and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      af_reg       <= 1'b0;
      bf_reg       <= 1'b0;
      a_seen_reg   <= 1'b0;
      tag_pend_reg <= 1'b0;
      tag_addr_reg <= 16'h0000;
    end else if (start) begin
      af_reg       <= 1'b0; // [RULE10]
      bf_reg       <= 1'b0; // [RULE11]
      a_seen_reg   <= 1'b0;
      tag_pend_reg <= 1'b0;
    end else if (armed) begin
      if (a_eq) begin
        af_reg     <= 1'b1; // [RULE10]
        a_seen_reg <= 1'b1;
      end
      if (b_eq) begin
        bf_reg <= 1'b1; // [RULE11]
      end
      if (tag_sel && raw_trig) begin
        tag_pend_reg <= 1'b1; // [RULE3]
        tag_addr_reg <= access_i.addr;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= dtsl_pkg::CNT_RESET;
    end else if (start) begin
      cnt_reg <= dtsl_pkg::CNT_RESET; // [RULE15]
    end else if (run_end) begin
      cnt_reg <= push && !fifo_full ? fifo_cnt + 4'h1 : fifo_cnt; // [RULE15]
    end
  end

  // ----------------------------------------------------------------
  // apb read path and outputs; status has no write path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_reg <= 1'b0;
      prdata_o   <= 32'h0000_0000;
      pslverr_o  <= 1'b0;
    end else begin
      pready_reg <= psel_i && penable_i && !pready_reg;
      pslverr_o  <= psel_i && penable_i && !pready_reg && !hit_any;
      if (psel_i && penable_i && !pready_reg && !pwrite_i) begin
        prdata_o <= 32'h0000_0000;
        if (hit_cfg) prdata_o[7:0] <= cfg_reg;
        if (hit_st)  prdata_o[7:0] <= {af_reg, bf_reg,
                                       armed && ctl_reg[7],
                                       1'b0, cnt_reg}; // [RULE9] [RULE12]
        if (hit_ctl) prdata_o[7:0] <= {ctl_reg[7], armed, ctl_reg[5:0]};
        if (hit_fh)  prdata_o[7:0] <= head[15:8];
        if (hit_fl)  prdata_o[7:0] <= head[7:0];
      end
    end
  end
  assign pready_o = pready_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trigger_o <= 1'b0;
      armed_o   <= 1'b0;
    end else begin
      trigger_o <= trig_event;
      armed_o   <= (state_next != dtsl_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cfg_locked;
    @(posedge clk_i) disable iff (!nrst_i)
      armed && wr_done && hit_cfg |=> $stable(cfg_reg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) // [RULE1]
    else $error("trigger config changed while armed");

  property p_cfg_rsvd;
    @(posedge clk_i) disable iff (!nrst_i)
      wr_done && hit_cfg |=> cfg_reg[5:4] == 2'b00;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) // [RULE2]
    else $error("reserved config bits not zero");

  property p_force_end;
    @(posedge clk_i) disable iff (!nrst_i)
      !tag_sel && state_reg == dtsl_pkg::ST_END_TRACE && raw_trig
      |=> state_reg == dtsl_pkg::ST_IDLE ##1 !armed_o;
  endproperty
  a_force_end: assert property (p_force_end) // [RULE3] [RULE13]
    else $error("force trigger did not end the trace");

  property p_event_begin;
    @(posedge clk_i) disable iff (!nrst_i)
      start && ev_mode |=> state_reg == dtsl_pkg::ST_BEGIN_WAIT;
  endproperty
  a_event_begin: assert property (p_event_begin) // [RULE5]
    else $error("event mode run not a begin trace");

  property p_no_trig;
    @(posedge clk_i) disable iff (!nrst_i)
      mode > 4'h8 && !tag_sel |=> !trigger_o;
  endproperty
  a_no_trig: assert property (p_no_trig) // [RULE8]
    else $error("trigger in a no-trigger mode");

  property p_flags_clear;
    @(posedge clk_i) disable iff (!nrst_i)
      start |=> !af_reg && !bf_reg && cnt_reg == 4'h0;
  endproperty
  a_flags_clear: assert property (p_flags_clear) // [RULE10] [RULE11]
    else $error("flags not cleared at run start");

  property p_arm_mirror;
    @(posedge clk_i) disable iff (!nrst_i)
      start |=> armed_o && armed;
  endproperty
  a_arm_mirror: assert property (p_arm_mirror) // [RULE12]
    else $error("arm write did not arm");

  property p_manual_stop;
    @(posedge clk_i) disable iff (!nrst_i)
      stop |=> !armed ##1 !armed_o;
  endproperty
  a_manual_stop: assert property (p_manual_stop) // [RULE14]
    else $error("manual stop did not end the run");

  property p_cnt_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      !armed && !start |=> $stable(cnt_reg);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) // [RULE16] [RULE20]
    else $error("valid count moved while idle");

  property p_cnt_max;
    @(posedge clk_i) disable iff (!nrst_i)
      cnt_reg <= 4'h8;
  endproperty
  a_cnt_max: assert property (p_cnt_max) // [RULE15]
    else $error("valid count above eight");

  property p_secure;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(ctl_reg[7]) |-> !$past(secure_i);
  endproperty
  a_secure: assert property (p_secure) // [RULE18]
    else $error("enable set while secure");

  c_end_trace: cover property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == dtsl_pkg::ST_END_TRACE ##1 state_reg == dtsl_pkg::ST_IDLE);
  c_begin_full: cover property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == dtsl_pkg::ST_BEGIN_FILL && fifo_full);
  c_profile: cover property (@(posedge clk_i) disable iff (!nrst_i)
    pop);
endmodule

// file: inc/dtsl_pkg.sv
// package of the debug trigger and status logic: offsets, fields, modes
// assumes a 32-bit apb slave and a cpu bus with 16-bit addresses
package dtsl_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_TRIG_CFG   = 12'h000;
  localparam logic [11:0] OFF_RUN_STATUS = 12'h004;
  localparam logic [11:0] OFF_DEBUG_CTRL = 12'h008;
  localparam logic [11:0] OFF_FIFO_HIGH  = 12'h00C;
  localparam logic [11:0] OFF_FIFO_LOW   = 12'h010;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_TAG_BIT   = 7;
  localparam int CFG_BEGIN_BIT = 6;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hCF;
  localparam int CTL_EN_BIT    = 7;
  localparam int CTL_ARM_BIT   = 6;
  localparam int CTL_RWA_BIT   = 3;
  localparam int CTL_RWAEN_BIT = 2;
  localparam int CTL_RWB_BIT   = 1;
  localparam int CTL_RWBEN_BIT = 0;
  localparam int ST_AF_BIT     = 7;
  localparam int ST_BF_BIT     = 6;
  localparam int ST_RUN_ARMED_STATUS_BIT   = 5;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [3:0] CNT_RESET  = 4'h0;
  localparam logic [3:0] FIFO_DEPTH = 4'h8;

  // ----------------------------------------------------------------
  // trigger modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_A_ONLY     = 4'h0,
    MODE_A_OR_B     = 4'h1,
    MODE_A_THEN_B   = 4'h2,
    MODE_EV_B       = 4'h3,
    MODE_A_THEN_EVB = 4'h4,
    MODE_A_AND_BD   = 4'h5,
    MODE_A_NOT_BD   = 4'h6,
    MODE_INSIDE     = 4'h7,
    MODE_OUTSIDE    = 4'h8
  } dtsl_mode_t;

  // run states
  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_END_TRACE  = 2'b01,
    ST_BEGIN_WAIT = 2'b10,
    ST_BEGIN_FILL = 2'b11
  } dtsl_state_t;

  // one cpu bus access as seen by the comparators
  typedef struct packed {
    logic        valid;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } dtsl_access_t;

endpackage

// file: rtl/dtsl_cmp.sv
// one address comparator with read/write qualification
// assumes access fields are stable within the cycle they are valid
`timescale 1ns/1ps
module dtsl_cmp (
  // access under test
  input  wire logic                  valid_i,
  input  wire logic                  rd_i,
  input  wire logic [15:0]           addr_i,
  // compare value and qualifier
  input  wire logic [15:0]           value_i,
  input  wire logic                  rw_en_i,
  input  wire logic                  rw_val_i,
  // results
  output logic                       eq_o,
  output logic                       below_o,
  output logic                       above_o
);
  logic ok;
  // qualifier off means both reads and writes may match
  assign ok      = valid_i && (!rw_en_i || (rd_i == rw_val_i));
  assign eq_o    = ok && (addr_i == value_i);
  assign below_o = ok && (addr_i < value_i);
  assign above_o = ok && (addr_i > value_i);
endmodule

// file: rtl/dtsl_fifo.sv
// eight-word capture fifo with circular fill and profiling reads
// assumes clear, realign, push and pop come from the run logic
`timescale 1ns/1ps
module dtsl_fifo (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // run control
  input  wire logic        clear_i,
  input  wire logic        realign_i,
  // fill side
  input  wire logic        push_i,
  input  wire logic [15:0] push_data_i,
  // read side
  input  wire logic        pop_i,
  input  wire logic [15:0] pop_fill_i,
  output logic      [15:0] head_o,
  output logic      [3:0]  count_o,
  output logic             full_o
);
  logic [15:0] mem_reg [8];
  logic [2:0]  wr_ptr_reg;
  logic [2:0]  rd_ptr_reg;
  logic [3:0]  cnt_reg;

  assign head_o  = mem_reg[rd_ptr_reg];
  assign count_o = cnt_reg;
  assign full_o  = (cnt_reg == dtsl_pkg::FIFO_DEPTH);

  // ----------------------------------------------------------------
  // storage: on a pop the slot just read takes the profile address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 8; i++) begin
        mem_reg[i] <= 16'h0000;
      end
    end else if (push_i) begin
      mem_reg[wr_ptr_reg] <= push_data_i;
    end else if (pop_i) begin
      mem_reg[rd_ptr_reg] <= pop_fill_i; // [RULE19]
    end
  end

  // ----------------------------------------------------------------
  // pointers: realign points the reader at the oldest word
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
      cnt_reg    <= dtsl_pkg::CNT_RESET;
    end else if (clear_i) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
      cnt_reg    <= dtsl_pkg::CNT_RESET;
    end else begin
      if (push_i) begin
        wr_ptr_reg <= wr_ptr_reg + 3'h1;
        if (!full_o) begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
      if (realign_i) begin
        // a push into a full fifo in the ending cycle drops the oldest
        rd_ptr_reg <= (push_i && full_o) ? wr_ptr_reg + 3'h1 :
                      wr_ptr_reg - cnt_reg[2:0];
      end else if (pop_i) begin
        rd_ptr_reg <= rd_ptr_reg + 3'h1; // [RULE19]
      end
    end
  end
endmodule

// file: sim/dtsl_host.sv
// apb host model standing in for the external debug host
// assumes the slave answers with pready; bench bounds any hang
`timescale 1ns/1ps
module dtsl_host (
  // clock
  input  wire logic        clk_i,
  // apb master side
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [11:0] paddr_o,
  output logic      [31:0] pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 12'h000;
    pwdata_o  = 32'h0000_0000;
  end
  // one transfer; an idle cycle follows so drives never clash
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d, output logic [31:0] r,
                      output logic e);
    psel_o   <= 1'b1;
    pwrite_o <= w;
    paddr_o  <= a;
    pwdata_o <= {24'h000000, d};
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// file: sim/tb_dtsl_core.sv
// self-checking bench of the debug trigger and status logic
// assumes dtsl_host as apb master; cpu events driven here
`timescale 1ns/1ps
module tb_dtsl_core;
  localparam logic [11:0] CFG = dtsl_pkg::OFF_TRIG_CFG;
  localparam logic [11:0] STS = dtsl_pkg::OFF_RUN_STATUS;
  localparam logic [11:0] CTL = dtsl_pkg::OFF_DEBUG_CTRL;
  logic clk_i = 1'b0, nrst_i = 1'b0, psel, penable, pwrite;
  logic pready, pslverr, trigger, armed, cof_v = 1'b0, sec = 1'b0;
  logic exv = 1'b0;
  logic t, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  dtsl_pkg::dtsl_access_t acc = '0;
  int n_fail = 0, compares = 0;
  initial forever #10 clk_i = ~clk_i;
  dtsl_host u_host (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  dtsl_core u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .access_i(acc), .exec_valid_i(exv),
    .exec_addr_i(16'h1234), .cof_valid_i(cof_v),
    .cof_addr_i(16'h5A3C), .last_opcode_addr_i(16'h0F0F),
    .secure_i(sec), .cmp_a_value_i(16'h1234),
    .cmp_b_value_i(16'h0000), .trigger_o(trigger), .armed_o(armed));
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic chk(input logic [11:0] a, input logic [7:0] x);
    u_host.xfer(1'b0, a, 8'h00, r, e);
    compares++;
    if (r !== {24'h000000, x} || e !== 1'b0) begin
      n_fail++;
      $display("ERROR %0t read %h got %h", $time, a, r);
    end
  endtask
  // armed output compared where it stands, before the edge updates it
  task automatic arm(input logic x);
    compares++;
    if (armed !== x) begin
      n_fail++;
      $display("ERROR %0t armed %b", $time, armed);
    end
  endtask
  // one cpu access at comparator A, or execution of that opcode,
  // then look at the one-cycle trigger pulse while it stands
  task automatic hit(input logic ex, input logic x);
    if (ex) exv <= 1'b1;
    else acc <= {1'b1, 1'b1, 16'h1234, 8'h00};
    @(posedge clk_i);
    exv       <= 1'b0;
    acc.valid <= 1'b0;
    @(posedge clk_i);
    t = trigger;
    compares++;
    if (t !== x) begin
      n_fail++;
      $display("ERROR %0t trigger %b", $time, t);
    end
  endtask
  task print_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    chk(CFG, 8'h00);
    chk(STS, 8'h00);
    wr(CFG, 8'hFF);
    chk(CFG, 8'hCF);
    wr(STS, 8'hFF);
    chk(STS, 8'h00);
    u_host.xfer(1'b0, 12'h020, 8'h00, r, e);
    compares++;
    if (e !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t unmapped read not refused", $time);
    end
    wr(CFG, 8'h00);
    wr(CTL, 8'hC0);
    arm(1'b1);
    chk(STS, 8'h20);
    wr(CFG, 8'h07);
    chk(CFG, 8'h00);
    hit(1'b0, 1'b1);
    arm(1'b0);
    chk(STS, 8'h80);
    wr(CFG, 8'h80);
    wr(CTL, 8'hC0);
    hit(1'b0, 1'b0);
    hit(1'b1, 1'b1);
    wr(CFG, 8'h08);
    wr(CTL, 8'hC0);
    hit(1'b0, 1'b1);
    wr(CFG, 8'h09);
    wr(CTL, 8'hC0);
    hit(1'b0, 1'b0);
    chk(STS, 8'hA0);
    wr(CTL, 8'h80);
    chk(STS, 8'h80);
    wr(CFG, 8'h40);
    wr(CTL, 8'hC0);
    hit(1'b0, 1'b1);
    repeat (8) begin
      cof_v <= 1'b1;
      @(posedge clk_i);
      cof_v <= 1'b0;
      @(posedge clk_i);
    end
    chk(STS, 8'h88);
    chk(dtsl_pkg::OFF_FIFO_LOW, 8'h3C);
    chk(STS, 8'h88);
    sec <= 1'b1;
    wr(CTL, 8'hC0);
    chk(CTL, 8'h00);
    print_verdict;
  end
endmodule
